// File: hw/dsr_formatter.sv
// Command decoder and long-word response formatter of the DSI accelerometer slave.
`timescale 1ns/1ns
// Contract
// - Implemented commands except clear answer 16 bits, device address on top nibble.
// - After reset the address loads the programmed address, else zero.
// - A zero address is replaced by the init address; nonzero is kept.
// - Acceleration answer holds 10-bit result, ground fault and status above.
// - Attribute bits mirror config one bits 1:0 when locked, else 10.
// - Init latches bank bits; invalid bank suppresses the answer.
// - NVM access uses bank bits with register address to pick a nibble.
// - Init answer bus fault bit shows the bus test result.
// - Master's switch bit closes the switch unless the bus test fails; answers report its state.
// - Format command 3-bit field selects one of eight format registers.
// - Format data field is write data; answer returns current contents.
// - Format write when R/W set; read when clear unless global.
// - Ground fault bit shown only when ground loss detection is enabled.
// - Programming-enable bit at init enables the OTP programming path.
// - Init answers report the address assigned by that command.
// - NVM low nibble is write data if programming, else read data.
// - Summary status ORs self-test, parity, fuse, undervoltage, ground fault.
// - Self-test bit shows whether the stimulus is active.
// - Undervoltage flag sets whenever hold capacitor voltage is low.
// - No answer on CRC error or reserved or unimplemented code.
// - Init commands assigning address zero are ignored.
// - Each answer is given exactly once, with no retry.
module dsr_formatter #(
  parameter logic [2:0] VERSION = dsr_pkg::VERSION_DEF
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_CRC_OK_I,
  input wire logic [3:0] CMD_ADDR_I,
  input wire logic [3:0] CMD_CODE_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic [3:0] PROG_ADDR_I,
  input wire logic BUS_TEST_FAIL_I,
  input wire logic [9:0] ACCEL_RESULT_I,
  input wire logic GROUND_FAULT_I,
  input wire logic PARITY_FAULT_I,
  input wire logic FUSE_FAULT_I,
  input wire logic HOLD_CAPACITOR_NODE_LOW_I,
  output logic RESP_VALID_O,
  output logic [15:0] RESP_DATA_O,
  output logic BUS_SWITCH_O,
  output logic OTP_PROG_EN_O,
  output logic OTP_WR_O,
  output logic [5:0] OTP_WR_SEL_O,
  output logic [3:0] OTP_WR_DATA_O,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] dev_addr_r;
  logic addr_loaded_r;
  logic [1:0] bank_sel_r;
  logic bus_switch_r;
  logic otp_prog_enable_r;
  logic selftest_r;
  logic uv_latch_r;
  logic [1:0] device_config_one_r;
  logic second_lock_bit_r;
  logic ground_loss_detect_en_r;
  logic [3:0] fmt_reg_r [8];
  logic [7:0] user_reg_r [16];
  logic resp_valid_r;
  logic [15:0] resp_data_r;

  logic take;
  logic is_global;
  logic addr_hit;
  logic is_init;
  logic init_ok;
  logic [3:0] assigned_addr;
  logic [1:0] bank_cmd;
  logic [2:0] fmt_reg_sel;
  logic [3:0] fmt_reg_value;
  logic fmt_wr;
  logic [3:0] user_reg_sel;
  logic [3:0] nvm_nib;
  logic ground_fault_flag;
  logic summary_flag;
  logic summary_no_st;
  logic [1:0] attr_code;
  logic [7:0] stat_byte;
  logic clear_cmd;
  logic nvm_wr;

  assign take = CMD_VALID_I && CMD_CRC_OK_I;
  assign is_global = (CMD_ADDR_I == dsr_pkg::GLOBAL_ADDR);
  assign addr_hit = (CMD_ADDR_I == dev_addr_r) && !is_global;
  assign is_init = (CMD_CODE_I == dsr_pkg::CMD_INIT) || (CMD_CODE_I == dsr_pkg::CMD_RINIT);
  assign assigned_addr = CMD_DATA_I[3:0];
  assign bank_cmd = CMD_DATA_I[dsr_pkg::BANK_HI:dsr_pkg::BANK_LO];
  // An unassigned device takes the new address; an assigned one must see its own.
  assign init_ok = take && is_init && (assigned_addr != dsr_pkg::GLOBAL_ADDR)
      && (dev_addr_r == dsr_pkg::GLOBAL_ADDR ? is_global
          : (CMD_ADDR_I == dev_addr_r && assigned_addr == dev_addr_r))
      && (bank_cmd != dsr_pkg::BANK_INVALID);
  assign fmt_reg_sel = CMD_DATA_I[6:4];
  assign fmt_reg_value = CMD_DATA_I[3:0];
  // Global format commands carry no answer, so they always write.
  assign fmt_wr = take && (CMD_CODE_I == dsr_pkg::CMD_FMT) && (addr_hit || is_global)
      && (CMD_DATA_I[dsr_pkg::RW_BIT] || is_global);
  assign user_reg_sel = CMD_DATA_I[7:4];
  assign nvm_nib = bank_sel_r[0] ? user_reg_r[user_reg_sel][7:4] : user_reg_r[user_reg_sel][3:0];
  assign nvm_wr = take && addr_hit && (CMD_CODE_I == dsr_pkg::CMD_NVM) && otp_prog_enable_r;
  assign clear_cmd = take && addr_hit && (CMD_CODE_I == dsr_pkg::CMD_CLEAR);
  assign ground_fault_flag = ground_loss_detect_en_r && GROUND_FAULT_I;
  assign summary_flag = selftest_r || PARITY_FAULT_I || FUSE_FAULT_I
      || uv_latch_r || ground_fault_flag;
  assign summary_no_st = PARITY_FAULT_I || FUSE_FAULT_I || uv_latch_r || ground_fault_flag;
  assign attr_code = second_lock_bit_r ? device_config_one_r : dsr_pkg::ATTR_UNLOCKED;
  assign stat_byte = {otp_prog_enable_r, uv_latch_r, selftest_r, bus_switch_r,
      attr_code, summary_flag, ground_fault_flag};

  ////////////////////////////////////////////////////////////////////////////
  // The programmed address is caught one cycle after reset release.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr_r <= 4'h0;
      addr_loaded_r <= 1'b0;
    end else if (!addr_loaded_r) begin
      dev_addr_r <= PROG_ADDR_I;
      addr_loaded_r <= 1'b1;
    end else if (init_ok) begin
      dev_addr_r <= assigned_addr;
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      bank_sel_r <= 2'h0;
      bus_switch_r <= 1'b0;
      otp_prog_enable_r <= 1'b0;
    end else if (init_ok) begin
      bank_sel_r <= bank_cmd;
      bus_switch_r <= CMD_DATA_I[dsr_pkg::SW_BIT] && !BUS_TEST_FAIL_I;
      otp_prog_enable_r <= CMD_DATA_I[dsr_pkg::OTP_BIT];
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      selftest_r <= 1'b0;
    end else if (take && addr_hit && CMD_CODE_I == dsr_pkg::CMD_ST_ON) begin
      selftest_r <= 1'b1;
    end else if (take && addr_hit && CMD_CODE_I == dsr_pkg::CMD_ST_OFF) begin
      selftest_r <= 1'b0;
    end
  end

  // A transient dip stays visible until cleared; a low level present at clear wins.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      uv_latch_r <= 1'b0;
    end else if (HOLD_CAPACITOR_NODE_LOW_I) begin
      uv_latch_r <= 1'b1;
    end else if (clear_cmd) begin
      uv_latch_r <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_fmt
      always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
          fmt_reg_r[gi] <= 4'h0;
        end else if (fmt_wr && fmt_reg_sel == 3'(gi)) begin
          fmt_reg_r[gi] <= fmt_reg_value;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // PREADY is tied high: every register answers in the access cycle itself.
  logic apb_wr;
  logic user_hit;
  logic [3:0] user_idx;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign user_hit = (PADDR[7:6] == dsr_pkg::OFS_USER[7:6]) && (PADDR[1:0] == 2'h0);
  assign user_idx = PADDR[5:2];

  // Fuses model: NVM programming only sets bits, matching one-time memory; an APB write replaces the whole byte.
  generate
    for (gi = 0; gi < 16; gi++) begin : g_user
      always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
          user_reg_r[gi] <= 8'h00;
        end else if (apb_wr && user_hit && user_idx == 4'(gi)) begin
          user_reg_r[gi] <= PWDATA[7:0];
        end else if (nvm_wr && user_reg_sel == 4'(gi)) begin
          if (bank_sel_r[0]) begin
            user_reg_r[gi][7:4] <= user_reg_r[gi][7:4] | CMD_DATA_I[3:0];
          end else begin
            user_reg_r[gi][3:0] <= user_reg_r[gi][3:0] | CMD_DATA_I[3:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      device_config_one_r <= 2'h0;
      second_lock_bit_r <= 1'b0;
      ground_loss_detect_en_r <= 1'b0;
    end else if (apb_wr && PADDR == dsr_pkg::OFS_CTRL) begin
      {ground_loss_detect_en_r, second_lock_bit_r, device_config_one_r} <= PWDATA[3:0];
    end
  end

  always_comb begin
    PRDATA = 32'h0000_0000;
    PSLVERR = 1'b0;
    if (PADDR == dsr_pkg::OFS_CTRL) begin
      PRDATA[3:0] = {ground_loss_detect_en_r, second_lock_bit_r, device_config_one_r};
    end else if (PADDR == dsr_pkg::OFS_STAT) begin
      // Status is read-only; a write is flagged and changes nothing.
      PSLVERR = PSEL && PENABLE && PWRITE;
      PRDATA[11:0] = {ground_fault_flag, summary_flag, uv_latch_r, selftest_r,
          otp_prog_enable_r, bus_switch_r, bank_sel_r, dev_addr_r};
    end else if (PADDR[7:5] == dsr_pkg::OFS_FMT[7:5] && PADDR[4:2] != 3'h0
        && PADDR[1:0] == 2'h0) begin
      PRDATA[31:0] = {fmt_reg_r[7], fmt_reg_r[6], fmt_reg_r[5], fmt_reg_r[4],
          fmt_reg_r[3], fmt_reg_r[2], fmt_reg_r[1], fmt_reg_r[0]};
      PSLVERR = PSEL && PENABLE && (PWRITE || PADDR != dsr_pkg::OFS_FMT);
    end else if (user_hit) begin
      PRDATA[7:0] = user_reg_r[user_idx];
    end else begin
      PSLVERR = PSEL && PENABLE;
    end
  end
  assign PREADY = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Answers are built in the cycle the command is taken and shown for one cycle.
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
      resp_data_r <= 16'h0000;
    end else begin
      resp_valid_r <= 1'b0;
      if (init_ok) begin
        resp_valid_r <= 1'b1;
        resp_data_r <= {assigned_addr, 3'h0, BUS_TEST_FAIL_I, CMD_DATA_I[7],
            CMD_DATA_I[6] && !BUS_TEST_FAIL_I, bank_cmd, assigned_addr};
      end else if (take && addr_hit) begin
        resp_valid_r <= 1'b1;
        case (CMD_CODE_I)
          dsr_pkg::CMD_STATUS: begin
            resp_data_r <= {dev_addr_r, 4'h0, stat_byte};
          end
          // Disable answers with the new state, so the stimulus no longer counts in the summary.
          dsr_pkg::CMD_ST_OFF: begin
            resp_data_r <= {dev_addr_r, 4'h0, stat_byte[7:6], 1'b0, stat_byte[4:2],
                summary_no_st, stat_byte[0]};
          end
          dsr_pkg::CMD_ST_ON: begin
            resp_data_r <= {dev_addr_r, 4'h0, stat_byte[7:6], 1'b1, stat_byte[4:2], 1'b1, stat_byte[0]};
          end
          dsr_pkg::CMD_ACCEL: begin
            resp_data_r <= {dev_addr_r, ground_fault_flag, summary_flag, ACCEL_RESULT_I};
          end
          dsr_pkg::CMD_ID: begin
            resp_data_r <= {dev_addr_r, 4'h0, VERSION, dsr_pkg::ID_TAIL};
          end
          dsr_pkg::CMD_NVM: begin
            resp_data_r <= {dev_addr_r, user_reg_sel, 4'h0,
                otp_prog_enable_r ? CMD_DATA_I[3:0] : nvm_nib};
          end
          dsr_pkg::CMD_FMT: begin
            resp_data_r <= {dev_addr_r, dsr_pkg::FMT_MARK, CMD_DATA_I[7:4],
                fmt_reg_r[fmt_reg_sel]};
          end
          dsr_pkg::CMD_REGRD: begin
            resp_data_r <= {dev_addr_r, CMD_DATA_I[3:0], user_reg_r[CMD_DATA_I[3:0]]};
          end
          default: begin
            resp_valid_r <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      OTP_WR_O <= 1'b0;
      OTP_WR_SEL_O <= 6'h00;
      OTP_WR_DATA_O <= 4'h0;
    end else begin
      OTP_WR_O <= nvm_wr;
      if (nvm_wr) begin
        OTP_WR_SEL_O <= {user_reg_sel, bank_sel_r};
        OTP_WR_DATA_O <= CMD_DATA_I[3:0];
      end
    end
  end

  assign RESP_VALID_O = resp_valid_r;
  assign RESP_DATA_O = resp_data_r;
  assign BUS_SWITCH_O = bus_switch_r;
  assign OTP_PROG_EN_O = otp_prog_enable_r;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] st_resp;
  assign st_resp = {dev_addr_r, 4'h0, stat_byte};

  sequence s_cmd_taken(logic [3:0] code);
    take && addr_hit && CMD_CODE_I == code;
  endsequence

  chk_resp_addr_nibble: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    take && addr_hit && !is_init |=> RESP_DATA_O[15:12] == $past(dev_addr_r) || !RESP_VALID_O)
    else $error("Answer address nibble wrong");
  chk_no_resp_bad_crc: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    CMD_VALID_I && !CMD_CRC_OK_I |=> !RESP_VALID_O)
    else $error("Answer after CRC error");
  chk_resp_once: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    RESP_VALID_O && !$past(take) |-> 1'b0)
    else $error("Answer without a command");
  chk_accel_layout: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_cmd_taken(dsr_pkg::CMD_ACCEL) |=> RESP_VALID_O
      && RESP_DATA_O[9:0] == $past(ACCEL_RESULT_I) && RESP_DATA_O[11] == $past(ground_fault_flag))
    else $error("Acceleration answer layout wrong");
  chk_attr_unlocked: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_cmd_taken(dsr_pkg::CMD_STATUS) && !second_lock_bit_r |=> RESP_DATA_O[3:2] == 2'h2)
    else $error("Attribute code not 10 while unlocked");
  chk_bad_bank_quiet: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    take && is_init && bank_cmd == dsr_pkg::BANK_INVALID |=> !RESP_VALID_O)
    else $error("Answer to init with invalid bank");
  chk_zero_assign_ign: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    take && is_init && assigned_addr == 4'h0 |=> !RESP_VALID_O && $stable(dev_addr_r))
    else $error("Init to address zero not ignored");
  chk_addr_kept: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    addr_loaded_r && dev_addr_r != 4'h0 |=> dev_addr_r == $past(dev_addr_r))
    else $error("Assigned address replaced");
  chk_gf_masked: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_cmd_taken(dsr_pkg::CMD_STATUS) && !ground_loss_detect_en_r |=> !RESP_DATA_O[0])
    else $error("Ground fault shown while detection off");
  chk_uv_sets: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    HOLD_CAPACITOR_NODE_LOW_I |=> uv_latch_r ##0 summary_flag)
    else $error("Undervoltage not flagged");
  chk_selftest_on: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_cmd_taken(dsr_pkg::CMD_ST_ON) |=> RESP_DATA_O[5] && selftest_r)
    else $error("Self-test flag not active");
  chk_status_word: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_cmd_taken(dsr_pkg::CMD_STATUS) |=> RESP_DATA_O == $past(st_resp))
    else $error("Status answer wrong");
  chk_init_answer: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    init_ok |=> RESP_VALID_O && RESP_DATA_O[3:0] == dev_addr_r
      && RESP_DATA_O[8] == $past(BUS_TEST_FAIL_I))
    else $error("Init answer wrong");
endmodule : dsr_formatter

// File: hw/dsr_pkg.sv
// Package with command codes, field positions and register map for the DSI response formatter.
package dsr_pkg;
  typedef enum logic [3:0] {
    CMD_INIT = 4'h0,
    CMD_STATUS = 4'h1,
    CMD_ACCEL = 4'h2,
    CMD_ID = 4'h4,
    CMD_CLEAR = 4'h7,
    CMD_NVM = 4'h9,
    CMD_FMT = 4'hA,
    CMD_REGRD = 4'hB,
    CMD_ST_OFF = 4'hC,
    CMD_ST_ON = 4'hD,
    CMD_RINIT = 4'hF
  } dsr_cmd_e;
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [1:0] BANK_INVALID = 2'h3;
  localparam logic [1:0] ATTR_UNLOCKED = 2'h2;
  localparam logic [3:0] FMT_MARK = 4'h6;
  localparam logic [4:0] ID_TAIL = 5'h04;
  localparam logic [2:0] VERSION_DEF = 3'h1;
  // Command data byte fields.
  localparam int OTP_BIT = 7;
  localparam int SW_BIT = 6;
  localparam int BANK_HI = 5;
  localparam int BANK_LO = 4;
  localparam int RW_BIT = 7;
  // APB map, byte addresses.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_FMT = 8'h08;
  localparam logic [7:0] OFS_USER = 8'h40;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Status register bit positions.
  localparam int ST_SW = 6;
  localparam int ST_PROG = 7;
  localparam int ST_TEST = 8;
  localparam int ST_UV = 9;
  localparam int ST_SUM = 10;
  localparam int ST_GF = 11;
endpackage : dsr_pkg

// File: testbench/dsr_master_model.sv
// Behavioural DSI bus master that hands decoded commands to the response formatter.
`timescale 1ns/1ns
module dsr_master_model (
  input wire logic clk_i,
  output logic cmd_valid_o,
  output logic crc_ok_o,
  output logic [3:0] addr_o,
  output logic [3:0] code_o,
  output logic [7:0] data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    crc_ok_o = 1'b0;
    addr_o = 4'h0;
    code_o = 4'h0;
    data_o = 8'h00;
  end
  // Idle fields carry the inverse of the last command, so a stale value never passes for a live one.
  task automatic send(input logic [3:0] a, input logic [3:0] c, input logic [7:0] d, input logic ok);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    crc_ok_o <= ok;
    addr_o <= a;
    code_o <= c;
    data_o <= d;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    crc_ok_o <= ~ok;
    addr_o <= ~a;
    code_o <= ~c;
    data_o <= ~d;
  endtask : send
endmodule : dsr_master_model

// File: testbench/test_dsi_slave_response_formatter.sv
// Self-checking testbench of the DSI response formatter.
`timescale 1ns/1ns
module test_dsi_slave_response_formatter;
  logic clk, rst_n, c_valid, c_ok, bus_fail, gnd, par, fuse, hold_capacitor_node, psel, penable, pwrite, pready, pslverr;
  logic [3:0] c_addr, c_code, prog_addr, wr_dat;
  logic [7:0] c_data, paddr;
  logic [9:0] accel;
  logic [31:0] pwdata, prdata, rd;
  logic resp_valid, sw, prog_en, otp_wr, err;
  logic [15:0] resp;
  logic [5:0] otp_sel, wr_sel;
  logic [3:0] otp_dat;
  int errors, checked, cyc, wr_cnt;
  dsr_master_model mst_u (.clk_i(clk), .cmd_valid_o(c_valid), .crc_ok_o(c_ok), .addr_o(c_addr),
    .code_o(c_code), .data_o(c_data));
  dsr_formatter dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(c_valid), .CMD_CRC_OK_I(c_ok),
    .CMD_ADDR_I(c_addr), .CMD_CODE_I(c_code), .CMD_DATA_I(c_data), .PROG_ADDR_I(prog_addr),
    .BUS_TEST_FAIL_I(bus_fail), .ACCEL_RESULT_I(accel), .GROUND_FAULT_I(gnd), .PARITY_FAULT_I(par),
    .FUSE_FAULT_I(fuse), .HOLD_CAPACITOR_NODE_LOW_I(hold_capacitor_node), .RESP_VALID_O(resp_valid), .RESP_DATA_O(resp),
    .BUS_SWITCH_O(sw), .OTP_PROG_EN_O(prog_en), .OTP_WR_O(otp_wr), .OTP_WR_SEL_O(otp_sel),
    .OTP_WR_DATA_O(otp_dat), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (otp_wr === 1'b1) begin
      wr_cnt++;
      wr_sel = otp_sel;
      wr_dat = otp_dat;
    end
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Watches three edges so that a late answer or a repeated one is counted too.
  task automatic cmd(input logic [3:0] a, input logic [3:0] c, input logic [7:0] d, input logic ok,
                     output int n, output logic [15:0] w);
    n = 0;
    w = 16'h0000;
    mst_u.send(a, c, d, ok);
    repeat (3) begin
      #1;
      if (resp_valid === 1'b1) begin
        n++;
        w = resp;
      end
      @(posedge clk);
    end
  endtask : cmd
  task automatic ask(input logic [3:0] a, input logic [3:0] c, input logic [7:0] d, input logic [15:0] exp);
    int n;
    logic [15:0] w;
    cmd(a, c, d, 1'b1, n, w);
    check(n, 1);
    check(w, exp);
  endtask : ask
  task automatic nope(input logic [3:0] a, input logic [3:0] c, input logic [7:0] d, input logic ok);
    int n;
    logic [15:0] w;
    cmd(a, c, d, ok, n, w);
    check(n, 0);
  endtask : nope
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, dsr_pkg::OFS_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, dsr_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b0);
    apb(1'b0, 8'h80, 32'h0);
    check(err, 1'b1);
    apb(1'b1, dsr_pkg::OFS_STAT, 32'hF);
    check(err, 1'b1);
  endtask : t_reset
  task automatic t_init();
    nope(4'h0, dsr_pkg::CMD_INIT, 8'h50, 1'b1);
    nope(4'h0, dsr_pkg::CMD_INIT, 8'h75, 1'b1);
    nope(4'h3, dsr_pkg::CMD_INIT, 8'h55, 1'b1);
    ask(4'h0, dsr_pkg::CMD_INIT, 8'h55, 16'h5055);
    check(sw, 1'b1);
    nope(4'h5, dsr_pkg::CMD_RINIT, 8'h57, 1'b1);
    bus_fail <= 1'b1;
    ask(4'h5, dsr_pkg::CMD_RINIT, 8'h55, 16'h5115);
    bus_fail <= 1'b0;
    check(sw, 1'b0);
  endtask : t_init
  task automatic t_flags();
    gnd <= 1'b1;
    accel <= 10'h2A5;
    apb(1'b1, dsr_pkg::OFS_CTRL, 32'hD);
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h5007);
    ask(4'h5, dsr_pkg::CMD_ACCEL, 8'h00, 16'h5EA5);
    apb(1'b1, dsr_pkg::OFS_CTRL, 32'h1);
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h5008);
    ask(4'h5, dsr_pkg::CMD_ACCEL, 8'h00, 16'h52A5);
    ask(4'h5, dsr_pkg::CMD_ST_ON, 8'h00, 16'h502A);
    ask(4'h5, dsr_pkg::CMD_ST_OFF, 8'h00, 16'h5008);
    par <= 1'b1;
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h500A);
    par <= 1'b0;
    fuse <= 1'b1;
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h500A);
    fuse <= 1'b0;
    hold_capacitor_node <= 1'b1;
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h504A);
    hold_capacitor_node <= 1'b0;
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h504A);
    nope(4'h5, dsr_pkg::CMD_CLEAR, 8'h00, 1'b1);
    ask(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 16'h5008);
    ask(4'h5, dsr_pkg::CMD_ID, 8'h00, 16'h5024);
  endtask : t_flags
  task automatic t_refuse();
    logic [3:0] bad [5] = '{4'h3, 4'h5, 4'h6, 4'h8, 4'hE};
    foreach (bad[i]) nope(4'h5, bad[i], 8'h00, 1'b1);
    nope(4'h5, dsr_pkg::CMD_STATUS, 8'h00, 1'b0);
    nope(4'h6, dsr_pkg::CMD_STATUS, 8'h00, 1'b1);
    nope(4'h0, dsr_pkg::CMD_STATUS, 8'h00, 1'b1);
  endtask : t_refuse
  task automatic t_format();
    ask(4'h5, dsr_pkg::CMD_FMT, 8'hB9, 16'h56B0);
    ask(4'h5, dsr_pkg::CMD_FMT, 8'h30, 16'h5639);
    nope(4'h0, dsr_pkg::CMD_FMT, 8'h35, 1'b1);
    ask(4'h5, dsr_pkg::CMD_FMT, 8'h30, 16'h5635);
    apb(1'b0, dsr_pkg::OFS_FMT, 32'h0);
    check(rd, 32'h0000_5000);
  endtask : t_format
  task automatic t_user();
    apb(1'b1, dsr_pkg::OFS_USER + 8'h08, 32'hA5);
    ask(4'h5, dsr_pkg::CMD_REGRD, 8'h02, 16'h52A5);
    ask(4'h5, dsr_pkg::CMD_NVM, 8'h20, 16'h520A);
    check(wr_cnt, 0);
    ask(4'h5, dsr_pkg::CMD_INIT, 8'h85, 16'h5085);
    check(prog_en, 1'b1);
    ask(4'h5, dsr_pkg::CMD_NVM, 8'h23, 16'h5203);
    check({wr_cnt[3:0], wr_sel, wr_dat}, {4'h1, 4'h2, 2'h0, 4'h3});
    ask(4'h5, dsr_pkg::CMD_REGRD, 8'h02, 16'h52A7);
  endtask : t_user
  // A second reset with a programmed address: the address loads and is then kept.
  task automatic t_preset();
    prog_addr <= 4'h9;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, dsr_pkg::OFS_STAT, 32'h0);
    check(rd, 32'h0000_0009);
    nope(4'h0, dsr_pkg::CMD_INIT, 8'h53, 1'b1);
    ask(4'h9, dsr_pkg::CMD_INIT, 8'h59, 16'h9059);
  endtask : t_preset
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, bus_fail, gnd, par, fuse, hold_capacitor_node, psel, penable, pwrite} = '0;
    prog_addr = 4'h0;
    accel = 10'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_init();
    t_flags();
    t_refuse();
    t_format();
    t_user();
    t_preset();
    complete_run();
  end
endmodule : test_dsi_slave_response_formatter
